//--- hdl/ssp_port.sv
// six-bit gpio port shared with two serial channels, axi4-lite slave
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_port
    import ssp_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // power state
    input wire logic hw_standby_i,
    input wire logic sw_standby_i,
    // axi4-lite write
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // serial channel controls and data
    input wire ssp_chan_type ch0_ctl_i,
    input wire ssp_chan_type ch1_ctl_i,
    input wire logic smart_card_select_i,
    input wire logic transmit_out_ch0_i,
    input wire logic tx_ch0_drive_i,
    input wire logic transmit_out_ch1_i,
    input wire logic serial_clock_ch0_out_i,
    input wire logic serial_clock_ch1_out_i,
    output logic receive_in_ch0_o,
    output logic receive_in_ch1_o,
    output logic serial_clock_ch0_in_o,
    output logic serial_clock_ch1_in_o,
    // interrupt lines
    input wire logic [1:0] irq_enable_i,
    output logic ext_interrupt_line4_o,
    output logic ext_interrupt_line5_o,
    // pins
    input wire logic [5:0] pin_i,
    output logic [5:0] pin_o,
    output logic [5:0] pin_oe_o
);
    logic [7:0] port_direction_reg_r;
    logic [7:0] port_output_latch_r;
    logic [5:0] pin_meta_r;
    logic [5:0] pin_sync_r;
    logic [5:0] per_own;
    logic [5:0] per_oe;
    logic [5:0] per_out;
    logic [5:0] pins_oe_nxt;
    logic [5:0] pins_out_nxt;
    logic [5:0] pins_oe_r;
    logic [5:0] pins_out_r;
    logic [7:0] read_nxt;
    logic aw_held_r;
    logic w_held_r;
    logic [15:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic w_strb0_r;
    logic wr_fire;
    logic rd_hit;
    logic wr_hit;
    logic hold_regs;

    // pin input synchroniser
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= pin_i;
            pin_sync_r <= pin_meta_r;
        end
    end

    // write channel capture
    assign s_axi_awready_o = !aw_held_r;
    assign s_axi_wready_o = !w_held_r;
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid_o;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb0_r <= 1'b0;
        end else begin
            if (s_axi_awvalid_i && !aw_held_r) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr_i[`SSP_ADDR_LO];
            end else if (wr_fire) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid_i && !w_held_r) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata_i;
                w_strb0_r <= s_axi_wstrb_i[0];
            end else if (wr_fire) begin
                w_held_r <= 1'b0;
            end
        end
    end

    assign wr_hit = (aw_addr_r == `SSP_DIR_ADDR) ||
                    (aw_addr_r == `SSP_DAT_ADDR);
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `SSP_RESP_OK;
        end else if (wr_fire) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_hit ? `SSP_RESP_OK : `SSP_RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // registers; reset and hardware standby both initialise, soft keeps
    assign hold_regs = sw_standby_i;
    always_ff @(posedge clock_i) begin
        if (rst_i || hw_standby_i) begin
            port_direction_reg_r <= `SSP_RESET_VAL;
        end else if (wr_fire && w_strb0_r && !hold_regs &&
                     aw_addr_r == `SSP_DIR_ADDR) begin
            port_direction_reg_r <= w_data_r[7:0];
        end
    end
    always_ff @(posedge clock_i) begin
        if (rst_i || hw_standby_i) begin
            port_output_latch_r <= `SSP_RESET_VAL;
        end else if (wr_fire && w_strb0_r && !hold_regs &&
                     aw_addr_r == `SSP_DAT_ADDR) begin
            port_output_latch_r <= w_data_r[7:0] | `SSP_RSVD_MASK;
        end
    end

    // peripheral ownership; no chip mode input at all
    always_comb begin
        per_own = '0;
        per_oe = '0;
        per_out = '0;
        if (ch1_ctl_i.clk_en_high) begin
            per_own[5] = 1'b1;
        end else if (ch1_ctl_i.clk_en_low || ch1_ctl_i.sync_mode) begin
            per_own[5] = 1'b1;
            per_oe[5] = 1'b1;
            per_out[5] = serial_clock_ch1_out_i;
        end
        if (ch0_ctl_i.clk_en_high) begin
            per_own[4] = 1'b1;
        end else if (ch0_ctl_i.clk_en_low || ch0_ctl_i.sync_mode) begin
            per_own[4] = 1'b1;
            per_oe[4] = 1'b1;
            per_out[4] = serial_clock_ch0_out_i;
        end
        per_own[3] = ch1_ctl_i.rx_en;
        per_own[2] = smart_card_select_i || ch0_ctl_i.rx_en;
        if (ch1_ctl_i.tx_en) begin
            per_own[1] = 1'b1;
            per_oe[1] = 1'b1;
            per_out[1] = transmit_out_ch1_i;
        end
        if (ch0_ctl_i.tx_en || smart_card_select_i) begin
            per_own[0] = 1'b1;
            per_oe[0] = !smart_card_select_i || tx_ch0_drive_i;
            per_out[0] = transmit_out_ch0_i;
        end
    end

    // pin drive; general pins follow direction and latch
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (per_own[i]) begin
                pins_oe_nxt[i] = per_oe[i];
                pins_out_nxt[i] = per_out[i];
            end else begin
                pins_oe_nxt[i] = port_direction_reg_r[i];
                pins_out_nxt[i] = port_output_latch_r[i];
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pins_oe_r <= '0;
            pins_out_r <= '0;
        end else if (!sw_standby_i) begin
            pins_oe_r <= pins_oe_nxt;
            pins_out_r <= pins_out_nxt;
        end
    end
    assign pin_oe_o = pins_oe_r;
    assign pin_o = pins_out_r;

    // receive and clock inputs, interrupt lines
    assign receive_in_ch0_o = pin_sync_r[2];
    assign receive_in_ch1_o = pin_sync_r[3];
    assign serial_clock_ch0_in_o = pin_sync_r[4];
    assign serial_clock_ch1_in_o = pin_sync_r[5];
    assign ext_interrupt_line4_o = irq_enable_i[0] && pin_sync_r[4];
    assign ext_interrupt_line5_o = irq_enable_i[1] && pin_sync_r[5];

    // read channel
    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign rd_hit = (s_axi_araddr_i[`SSP_ADDR_LO] == `SSP_DIR_ADDR) ||
                    (s_axi_araddr_i[`SSP_ADDR_LO] == `SSP_DAT_ADDR);
    always_comb begin
        read_nxt = '0;
        if (s_axi_araddr_i[`SSP_ADDR_LO] == `SSP_DIR_ADDR) begin
            read_nxt = `SSP_ALL_ONES;
        end else if (s_axi_araddr_i[`SSP_ADDR_LO] == `SSP_DAT_ADDR) begin
            read_nxt = `SSP_RSVD_MASK;
            for (int i = 0; i < 6; i++) begin
                read_nxt[i] = port_direction_reg_r[i] ?
                    port_output_latch_r[i] : pin_sync_r[i];
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= `SSP_RESP_OK;
        end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= {24'h000000, read_nxt};
            s_axi_rresp_o <= rd_hit ? `SSP_RESP_OK : `SSP_RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // assertions
    sequence dir_write_s;
        wr_fire && w_strb0_r && !hold_regs && !hw_standby_i &&
            aw_addr_r == `SSP_DIR_ADDR;
    endsequence
    dir_reset_a: assert property (@(posedge clock_i)
        rst_i || hw_standby_i |=> port_direction_reg_r == `SSP_RESET_VAL)
        else $error("direction not reset to C0");
    dat_reset_a: assert property (@(posedge clock_i)
        rst_i || hw_standby_i |=> port_output_latch_r == `SSP_RESET_VAL)
        else $error("data latch not reset to C0");
    dir_write_a: assert property (@(posedge clock_i)
        disable iff (rst_i)
        dir_write_s |=> port_direction_reg_r == $past(w_data_r[7:0]))
        else $error("direction write lost");
    dir_read_a: assert property (@(posedge clock_i)
        disable iff (rst_i)
        s_axi_arvalid_i && !s_axi_rvalid_o &&
        s_axi_araddr_i[`SSP_ADDR_LO] == `SSP_DIR_ADDR
        |=> s_axi_rdata_o[7:0] == `SSP_ALL_ONES)
        else $error("direction read not all ones");
    rsvd_bits_a: assert property (@(posedge clock_i)
        disable iff (rst_i)
        (port_output_latch_r & `SSP_RSVD_MASK) == `SSP_RSVD_MASK)
        else $error("reserved data bits not one");
    soft_keep_a: assert property (@(posedge clock_i)
        disable iff (rst_i)
        sw_standby_i && !hw_standby_i |=> $stable(pin_oe_o) &&
            $stable(pin_o) && $stable(port_direction_reg_r))
        else $error("state changed in software standby");
    irq_gate_a: assert property (@(posedge clock_i)
        disable iff (rst_i)
        !$past(rst_i) && !$past(rst_i, 2) |->
        ext_interrupt_line5_o == (irq_enable_i[1] && $past(pin_i[5], 2)))
        else $error("interrupt line 5 wrong");
    ext_interrupt_line4_gate_a: assert property (@(posedge clock_i)
        disable iff (rst_i)
        !$past(rst_i) && !$past(rst_i, 2) |->
        ext_interrupt_line4_o == (irq_enable_i[0] && $past(pin_i[4], 2)))
        else $error("interrupt line 4 wrong");
    pin1_tx_a: assert property (@(posedge clock_i)
        disable iff (rst_i)
        ch1_ctl_i.tx_en && !sw_standby_i |=> pin_oe_o[1])
        else $error("pin 1 not driven as transmit");
    pin5_clkin_a: assert property (@(posedge clock_i)
        disable iff (rst_i)
        ch1_ctl_i.clk_en_high && !sw_standby_i |=> !pin_oe_o[5])
        else $error("pin 5 driven while clock input");
    pin2_rx_a: assert property (@(posedge clock_i)
        disable iff (rst_i)
        smart_card_select_i && !sw_standby_i |=> !pin_oe_o[2])
        else $error("pin 2 driven while receive input");
endmodule // ssp_port

//--- hdl/ssp_map.svh
// register map and constants for the six-bit shared serial port
// Function
// - six bidirectional pins 0..5: general I/O, serial data or clock, two IRQ
// - pins 5 and 4 feed interrupt lines when enabled, regardless of direction
// - pin multiplexing identical in every chip mode; mode pins ignored
// - unowned pin: direction 1 drives latch, 0 makes it an input
// - direction register write-only; reads return all ones
// - direction loads 0xC0 on reset and hardware standby; kept in soft standby
// - in software standby, output pins keep driving their previous state
// - data read: latch when direction 1, sampled pin level when 0
// - data bits 7 and 6 reserved: writes ignored, read as one
// - data loads 0xC0 on reset and hardware standby; kept in soft standby
// - pin 5: ch1 clock in if enable high, else clock out if low or sync
// - pin 4: same clock scheme using channel 0 controls
// - pin 3: ch1 receive input when receive enable, else general I/O
// - pin 2: ch0 receive input when smart card select or receive enable
// - pin 0: ch0 transmit when transmit enable or smart card select; with smart card select driven only while tx_ch0_drive_i
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH
`define SSP_DIR_ADDR 16'hFFD0
`define SSP_DAT_ADDR 16'hFFD2
`define SSP_RESET_VAL 8'hC0
`define SSP_RSVD_MASK 8'hC0
`define SSP_ALL_ONES 8'hFF
`define SSP_RESP_OK 2'h0
`define SSP_RESP_SLVERR 2'h2
`define SSP_ADDR_LO 15:0
`endif

//--- hdl/ssp_pkg.sv
// types for the six-bit shared serial port
package ssp_pkg;
    typedef struct packed {
        logic clk_en_high;
        logic clk_en_low;
        logic sync_mode;
        logic rx_en;
        logic tx_en;
    } ssp_chan_type;
    typedef struct packed {
        logic [5:0] in;
        logic [5:0] out;
        logic [5:0] oe;
    } ssp_pins_type;
endpackage

//--- sim/ssp_pin_model.sv
// far-side pin model: resolves each pin from device and external drivers
`timescale 1ns/1ps
module ssp_pin_model (
    // device side
    input wire logic [5:0] pin_o_i,
    input wire logic [5:0] pin_oe_i,
    // external drivers
    input wire logic [5:0] ext_val_i,
    input wire logic [5:0] ext_en_i,
    // resolved pin levels
    output logic [5:0] level_o
);
    always_comb begin
        for (int k = 0; k < 6; k++) begin
            if (pin_oe_i[k]) level_o[k] = pin_o_i[k];
            else if (ext_en_i[k]) level_o[k] = ext_val_i[k];
            else level_o[k] = 1'b1; // released line sits at pull-up
        end
    end
endmodule // ssp_pin_model

//--- sim/tb_ssp_port.sv
// self-checking bench for the six-bit shared serial port
`timescale 1ns/1ps
`include "ssp_map.svh"
module tb_ssp_port;
    import ssp_pkg::*;
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] dat;
        logic [5:0] ext;
        ssp_chan_type c0;
        ssp_chan_type c1;
        logic sc;
        logic [1:0] ie;
        logic [7:0] rd;
        logic [5:0] oe;
        logic [5:0] o;
        logic [1:0] irq;
    } ssp_row_type;
    localparam ssp_row_type ROWS [13] = '{
        '{8'h3F, 8'h2A, 6'h00, 5'h00, 5'h00, 1'b0, 2'h3, 8'hEA, 6'h3F, 6'h2A, 2'h2},
        '{8'h00, 8'h15, 6'h1C, 5'h00, 5'h00, 1'b0, 2'h3, 8'hDC, 6'h00, 6'h00, 2'h1},
        '{8'h0F, 8'h35, 6'h30, 5'h00, 5'h00, 1'b0, 2'h2, 8'hF5, 6'h0F, 6'h05, 2'h2},
        '{8'h3F, 8'hFF, 6'h00, 5'h00, 5'h00, 1'b0, 2'h0, 8'hFF, 6'h3F, 6'h3F, 2'h0},
        '{8'h3F, 8'h00, 6'h00, 5'h00, 5'h01, 1'b0, 2'h0, 8'hC0, 6'h3F, 6'h02, 2'h0},
        '{8'h3F, 8'h00, 6'h00, 5'h01, 5'h00, 1'b0, 2'h0, 8'hC0, 6'h3F, 6'h01, 2'h0},
        '{8'h3F, 8'h00, 6'h00, 5'h00, 5'h00, 1'b1, 2'h0, 8'hC0, 6'h3B, 6'h01, 2'h0},
        '{8'h3F, 8'h00, 6'h00, 5'h02, 5'h00, 1'b0, 2'h0, 8'hC0, 6'h3B, 6'h00, 2'h0},
        '{8'h3F, 8'h00, 6'h00, 5'h00, 5'h02, 1'b0, 2'h0, 8'hC0, 6'h37, 6'h00, 2'h0},
        '{8'h3F, 8'h00, 6'h00, 5'h00, 5'h10, 1'b0, 2'h0, 8'hC0, 6'h1F, 6'h00, 2'h0},
        '{8'h3F, 8'h00, 6'h00, 5'h00, 5'h08, 1'b0, 2'h0, 8'hC0, 6'h3F, 6'h20, 2'h0},
        '{8'h3F, 8'h00, 6'h00, 5'h04, 5'h00, 1'b0, 2'h0, 8'hC0, 6'h3F, 6'h10, 2'h0},
        '{8'h3F, 8'h00, 6'h00, 5'h10, 5'h00, 1'b0, 2'h0, 8'hC0, 6'h2F, 6'h00, 2'h0}};
    logic clock_i = 1'b0, rst_i = 1'b1, hw_sb = 1'b0, sw_sb = 1'b0, sc = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, so = 1'b1;
    logic drv = 1'b1;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid;
    logic arready, rvalid, rx0, rx1, ck0, ck1;
    logic [1:0] bresp, rresp, resp, irq, ie = 2'h0;
    logic [5:0] pin_in, pin_out, pin_oe, ext = 6'h00, ext_en = 6'h00;
    logic [7:0] got;
    ssp_chan_type c0 = '0, c1 = '0;
    int num_errors = 0, comparisons = 0;
    ssp_port i_ssp_port (.clock_i(clock_i), .rst_i(rst_i),
        .hw_standby_i(hw_sb), .sw_standby_i(sw_sb),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .ch0_ctl_i(c0), .ch1_ctl_i(c1),
        .smart_card_select_i(sc), .transmit_out_ch0_i(so),
        .tx_ch0_drive_i(drv), .transmit_out_ch1_i(so),
        .serial_clock_ch0_out_i(so), .serial_clock_ch1_out_i(so),
        .receive_in_ch0_o(rx0), .receive_in_ch1_o(rx1),
        .serial_clock_ch0_in_o(ck0), .serial_clock_ch1_in_o(ck1),
        .irq_enable_i(ie), .ext_interrupt_line4_o(irq[0]),
        .ext_interrupt_line5_o(irq[1]), .pin_i(pin_in),
        .pin_o(pin_out), .pin_oe_o(pin_oe));
    ssp_pin_model i_ssp_pin_model (.pin_o_i(pin_out), .pin_oe_i(pin_oe),
        .ext_val_i(ext), .ext_en_i(ext_en), .level_o(pin_in));
    initial forever #5 clock_i = ~clock_i;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        awaddr <= {16'h0000, a};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        araddr <= {16'h0000, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock_i);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata[7:0];
        resp = rresp;
        rready <= 1'b0;
        @(posedge clock_i);
    endtask
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        ext_en <= 6'h3F;
        ext <= 6'h2A;
        repeat (3) @(posedge clock_i);
        chk(pin_oe, 6'h00);
        rd_reg(`SSP_DIR_ADDR, got);
        chk(got, `SSP_ALL_ONES);
        rd_reg(`SSP_DAT_ADDR, got);
        chk(got, 8'hEA);
        rd_reg(16'hFFD4, got);
        chk(resp, `SSP_RESP_SLVERR);
        wr_reg(16'hFFD4, 8'h3F);
        chk(resp, `SSP_RESP_SLVERR);
        foreach (ROWS[i]) begin
            c0 <= ROWS[i].c0;
            c1 <= ROWS[i].c1;
            sc <= ROWS[i].sc;
            ie <= ROWS[i].ie;
            ext <= ROWS[i].ext;
            ext_en <= ~ROWS[i].dir[5:0];
            wr_reg(`SSP_DIR_ADDR, ROWS[i].dir);
            wr_reg(`SSP_DAT_ADDR, ROWS[i].dat);
            repeat (3) @(posedge clock_i);
            rd_reg(`SSP_DAT_ADDR, got);
            chk(got, ROWS[i].rd);
            chk(pin_oe, ROWS[i].oe);
            chk(pin_out & pin_oe, ROWS[i].o);
            chk(irq, ROWS[i].irq);
        end
        chk(ck0, 1'b1);
        wr_reg(`SSP_DAT_ADDR, 8'h03);
        sc <= 1'b1;
        drv <= 1'b0;
        repeat (3) @(posedge clock_i);
        chk(pin_oe[0], 1'b0);
        drv <= 1'b1;
        so <= 1'b0;
        c1 <= 5'h01;
        repeat (2) @(posedge clock_i);
        chk(pin_oe[1:0], 2'h3);
        chk(pin_out[1:0], 2'h0);
        so <= 1'b1;
        sc <= 1'b0;
        c1 <= '0;
        c0 <= '0;
        wr_reg(`SSP_DAT_ADDR, 8'h2A);
        sw_sb <= 1'b1;
        wr_reg(`SSP_DAT_ADDR, 8'h15);
        repeat (3) @(posedge clock_i);
        chk(pin_out & pin_oe, 6'h2A);
        rd_reg(`SSP_DAT_ADDR, got);
        chk(got, 8'hEA);
        sw_sb <= 1'b0;
        hw_sb <= 1'b1;
        repeat (2) @(posedge clock_i);
        hw_sb <= 1'b0;
        ext_en <= 6'h3F;
        ext <= 6'h00;
        repeat (3) @(posedge clock_i);
        chk(pin_oe, 6'h00);
        rd_reg(`SSP_DAT_ADDR, got);
        chk(got, `SSP_RESET_VAL);
        ext <= 6'h2C;
        repeat (3) @(posedge clock_i);
        chk({ck1, ck0, rx1, rx0}, 4'hB);
        chk(irq, 2'h0);
        ie <= 2'h3;
        @(posedge clock_i);
        chk(irq, 2'h2);
        wrap_up();
    end
endmodule // tb_ssp_port
